// file: design/dctom_monitor.sv
// Dual channel torque-disable monitor: filtering, gate enable, faults.
// Assumes channel inputs and commands are synchronous levels or pulses.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module dctom_monitor #(
   parameter int FILT_CYC = dctom_pkg::PULSE_TOL_CYC,
   parameter int SKEW_LIM = dctom_pkg::SKEW_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Disable channels, high = operation permitted
   input wire logic disable_channel_one,
   input wire logic disable_channel_two,
   // Drive commands, one-cycle pulses
   input wire logic start_cmd,
   input wire logic stop_cmd,
   input wire logic fault_reset,
   // Indication setting
   input wire logic [dctom_pkg::IND_W-1:0] ind_sel,
   // Outputs
   output logic gate_enable,
   output logic running,
   output logic channel_one_loss_fault,
   output logic channel_two_loss_fault,
   output logic torque_disable_fault,
   output logic torque_disable_warning,
   output logic start_refused_warning,
   output logic ch_one_ok,
   output logic ch_two_ok
);
   import dctom_pkg::*;

   localparam int CW = $clog2(FILT_CYC + 1);
   localparam int SW = $clog2(SKEW_LIM + 1);

   logic [1:0] sync_one;
   logic [1:0] sync_two;
   logic [CW-1:0] low_one;
   logic [CW-1:0] low_two;
   logic [SW-1:0] skew_cnt;
   logic [IND_W-1:0] sel_q;
   logic reset_needed;
   dctom_state_e state;
   dctom_state_e next_state;

   // Low-time filter step: {count, channel ok}; short lows leave ok alone
   function automatic logic [CW:0] filt_step(input logic level,
                                             input logic [CW-1:0] low,
                                             input logic ok);
      logic [CW:0] res;
      res = {low, ok};
      if (level) begin
         res = {{CW{1'b0}}, 1'b1};
      end else if (low != CW'(FILT_CYC)) begin
         res = {CW'(low + 1'b1), ok};
      end else begin
         res = {low, 1'b0};
      end
      return res;
   endfunction

   // Second synchronizer stage output only
   wire logic in_one = sync_one[1];
   wire logic in_two = sync_two[1];
   wire logic both_ok = ch_one_ok & ch_two_ok;
   wire logic any_lost = ~ch_one_ok | ~ch_two_ok;
   wire logic one_only = ch_one_ok ^ ch_two_ok;
   wire logic skew_done = skew_cnt == SW'(SKEW_LIM);
   wire logic any_fault = channel_one_loss_fault | channel_two_loss_fault |
                          torque_disable_fault;
   wire logic start_ok = both_ok & ~any_fault & ~reset_needed;
   wire logic run_lost = (state == DCTOM_RUN) & any_lost;
   wire logic stop_lost = (state != DCTOM_RUN) & any_lost;
   wire logic loss_edge = any_lost & ~reset_needed & (state != DCTOM_LOCK);
   wire logic [CW:0] next_filt_one = filt_step(in_one, low_one, ch_one_ok);
   wire logic [CW:0] next_filt_two = filt_step(in_two, low_two, ch_two_ok);
   wire logic refuse = start_cmd & any_lost & (state != DCTOM_RUN);
   wire logic fault_clr = fault_reset & both_ok;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_one <= 2'h0;
         sync_two <= 2'h0;
      end else begin
         sync_one <= {sync_one[0], disable_channel_one};
         sync_two <= {sync_two[0], disable_channel_two};
      end
   end

   // Channel drops only after a low longer than the tolerance
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {low_one, ch_one_ok} <= '0;
         {low_two, ch_two_ok} <= '0;
      end else begin
         {low_one, ch_one_ok} <= next_filt_one;
         {low_two, ch_two_ok} <= next_filt_two;
      end
   end

   // Time a one-channel mismatch; the partner has the skew window
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         skew_cnt <= '0;
      end else if (!one_only) begin
         skew_cnt <= '0;
      end else if (!skew_done) begin
         skew_cnt <= skew_cnt + 1'b1;
      end
   end

   // Registered setting; only the indication flags and reset_needed below read it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_q <= IND_RESET;
      end else begin
         sel_q <= ind_sel;
      end
   end

   // Faults: set wins over reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         channel_one_loss_fault <= 1'b0;
      end else if (skew_done && !ch_one_ok) begin
         channel_one_loss_fault <= 1'b1;
      end else if (fault_clr) begin
         channel_one_loss_fault <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         channel_two_loss_fault <= 1'b0;
      end else if (skew_done && !ch_two_ok) begin
         channel_two_loss_fault <= 1'b1;
      end else if (fault_clr) begin
         channel_two_loss_fault <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         torque_disable_fault <= 1'b0;
      end else if (loss_edge && run_lost && sel_q[IND_RUN_FAULT]) begin
         torque_disable_fault <= 1'b1;
      end else if (fault_clr) begin
         torque_disable_fault <= 1'b0;
      end
   end

   // Warning follows the loss and clears once both channels are back
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         torque_disable_warning <= 1'b0;
      end else if ((run_lost && !sel_q[IND_RUN_FAULT]) ||
                   (stop_lost && sel_q[IND_STOP_EVT])) begin
         torque_disable_warning <= 1'b1;
      end else if (!any_lost) begin
         torque_disable_warning <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_needed <= 1'b0;
      end else if (any_lost && sel_q[IND_NEED_RST]) begin
         reset_needed <= 1'b1;
      end else if (fault_clr) begin
         reset_needed <= 1'b0;
      end
   end

   // Next run state; the setting enters this path only through start_ok
   always_comb begin
      next_state = state;
      case (state)
         DCTOM_IDLE: begin
            if (start_cmd && !any_lost && start_ok && !stop_cmd) begin
               next_state = DCTOM_RUN;
            end
         end
         DCTOM_RUN: begin
            if (any_lost) begin
               next_state = DCTOM_LOCK;
            end else if (stop_cmd) begin
               next_state = DCTOM_IDLE;
            end
         end
         default: begin
            if (both_ok) begin
               next_state = DCTOM_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= DCTOM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // A start while stopped with a channel lost gives a one-cycle warning
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_refused_warning <= 1'b0;
      end else begin
         start_refused_warning <= refuse;
      end
   end

   assign running = state == DCTOM_RUN;
   // Gate drive cut as soon as a filtered channel drops
   assign gate_enable = running & both_ok;
endmodule

// file: design/dctom_pkg.sv
// Constants for the dual channel torque-disable monitor.
// Assumes a single 50 MHz control clock and channel inputs high = permit.
// Notes on behaviour
// - Low pulses of up to 1 ms on either channel are ignored.
// - A de-energized disable input withdraws the gate drive enable.
// - A setting picks the indications for one or both lost, run or stop.
// - The setting changes reporting and the reset before restart, never the disable action.
// - A running drive stops when one or both channels are removed.
// - Start is refused until both channels are back and faults are reset.
// - Loss of exactly one channel for the whole skew window raises a fault.
// - After both channels close a reset is required if the setting says so.
// - No automatic restart; a fresh start command is needed.
// - Channel one alone and channel two alone raise distinct faults.
// - A start command while open and stopped gives a warning, no start.
package dctom_pkg;
   localparam int CLK_HZ = 50000000;
   localparam int PULSE_TOL_US = 1000;
   localparam int PULSE_TOL_CYC = PULSE_TOL_US * (CLK_HZ / 1000000);
   localparam int SKEW_MS = 200;
   localparam int SKEW_CYC = SKEW_MS * (CLK_HZ / 1000);
   // Indication setting: bit0 = event when stopped, bit1 = when running
   // as fault (else warning), bit2 = reset needed after both restore
   localparam int IND_W = 3;
   localparam logic [2:0] IND_RESET = 3'h3;
   localparam int IND_STOP_EVT = 0;
   localparam int IND_RUN_FAULT = 1;
   localparam int IND_NEED_RST = 2;
   typedef enum logic [1:0] {
      DCTOM_IDLE,
      DCTOM_RUN,
      DCTOM_LOCK
   } dctom_state_e;
endpackage

// file: verification/dctom_monitor_properties.sv
// Checker bound to the torque-disable monitor ports.
// Assumes one clock domain with asynchronous active-high reset.
`timescale 1ns/1ns
module dctom_monitor_props #(
   parameter int FILT_CYC = 8,
   parameter int SKEW_LIM = 20
) (
   input wire logic clk, rst, disable_channel_one, start_cmd, fault_reset,
   input wire logic gate_enable, running, ch_one_ok, ch_two_ok,
   input wire logic channel_one_loss_fault, channel_two_loss_fault,
   input wire logic start_refused_warning
);
   int cnt;
   wire both_ok = ch_one_ok && ch_two_ok;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles the filtered channels have disagreed, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt <= 0;
      else cnt <= (ch_one_ok != ch_two_ok) ? cnt + (cnt < 99) : 0;
   end
   sequence s_one_lost; !ch_one_ok && ch_two_ok; endsequence
   sequence s_two_lost; ch_one_ok && !ch_two_ok; endsequence
   property p_gate; gate_enable |-> running && both_ok; endproperty
   a_gate: assert property (p_gate)
      else $error("gate on without permit");
   property p_stop; running && !both_ok |=> !running; endproperty
   a_stop: assert property (p_stop)
      else $error("run kept after loss");
   property p_hold; !running && !both_ok |=> !running; endproperty
   a_hold: assert property (p_hold)
      else $error("start while lost");
   property p_start; $rose(running) |-> $past(start_cmd); endproperty
   a_start: assert property (p_start)
      else $error("start without command");
   property p_refuse;
      !running && start_cmd && !both_ok |=> start_refused_warning;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("no refusal warning");
   property p_f1;
      s_one_lost ##0 cnt > SKEW_LIM + 3 |-> channel_one_loss_fault;
   endproperty
   a_f1: assert property (p_f1)
      else $error("channel one fault missing");
   property p_f2;
      s_two_lost ##0 cnt > SKEW_LIM + 3 |-> channel_two_loss_fault;
   endproperty
   a_f2: assert property (p_f2)
      else $error("channel two fault missing");
   property p_filt;
      $fell(ch_one_ok) |->
         !$past(disable_channel_one, 4) &&
         !$past(disable_channel_one, FILT_CYC+1);
   endproperty
   a_filt: assert property (p_filt)
      else $error("short pulse dropped channel");
   property p_clr; $fell(channel_one_loss_fault) |-> $past(fault_reset);
   endproperty
   a_clr: assert property (p_clr)
      else $error("fault cleared without reset");
endmodule

// file: verification/dctom_switch_model.sv
// Model of the external two-contact activation switch.
// Assumes lag stays below the monitor's skew limit.
`timescale 1ns/1ns
module dctom_switch_model (
   // Clock and commands: solo 1 or 2 moves one contact only
   input wire logic clk,
   input wire logic permit,
   input wire logic [1:0] solo,
   input wire logic [7:0] lag,
   // Contacts, high = permit
   output logic disable_channel_one = 1'b1,
   output logic disable_channel_two = 1'b1
);
   int cnt = 0;
   // Second contact trails the first by lag cycles, both ways
   always @(posedge clk) begin
      cnt <= (disable_channel_two == permit) ? 0 : cnt + 1;
      if (solo != 2'h2) disable_channel_one <= permit;
      if (solo == 2'h2 || (solo == 2'h0 && cnt >= lag))
         disable_channel_two <= permit;
   end
endmodule

// file: verification/tb_dual_channel_torque_off_monitor.sv
// Self-checking bench for the torque-disable monitor and switch model.
// Assumes shortened filter and skew counts.
`timescale 1ns/1ns
module tb_dual_channel_torque_off_monitor;
   import dctom_pkg::*;
   logic clk = 0, rst = 1, permit = 1, start_cmd = 0, stop_cmd = 0;
   logic fault_reset = 0, disable_channel_one, disable_channel_two;
   logic gate_enable, running, channel_one_loss_fault, ch_one_ok, ch_two_ok;
   logic channel_two_loss_fault, torque_disable_fault, start_refused_warning;
   logic torque_disable_warning;
   logic [1:0] solo = 2'h0;
   logic [7:0] lag = 8'h0;
   logic [IND_W-1:0] ind_sel = 3'h0;
   int mismatches = 0, n_compared = 0, cycles = 0;
   always #10 clk = ~clk;
   dctom_switch_model dctom_switch_model_inst (
      .clk(clk), .permit(permit), .solo(solo), .lag(lag),
      .disable_channel_one(disable_channel_one),
      .disable_channel_two(disable_channel_two));
   dctom_monitor #(.FILT_CYC(8), .SKEW_LIM(20)) dctom_monitor_inst (
      .clk(clk), .rst(rst), .disable_channel_one(disable_channel_one),
      .disable_channel_two(disable_channel_two), .start_cmd(start_cmd),
      .stop_cmd(stop_cmd), .fault_reset(fault_reset), .ind_sel(ind_sel),
      .gate_enable(gate_enable), .running(running),
      .channel_one_loss_fault(channel_one_loss_fault),
      .channel_two_loss_fault(channel_two_loss_fault),
      .torque_disable_fault(torque_disable_fault),
      .torque_disable_warning(torque_disable_warning),
      .start_refused_warning(start_refused_warning),
      .ch_one_ok(ch_one_ok), .ch_two_ok(ch_two_ok));
   task chk(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   // k: 0 start, 1 stop, 2 fault reset
   task pulse(input int k);
      @(posedge clk);
      {fault_reset, stop_cmd, start_cmd} <= 3'h1 << k;
      @(posedge clk);
      {fault_reset, stop_cmd, start_cmd} <= 3'h0;
      @(negedge clk);
   endtask
   task t_start;
      pulse(0);
      chk("running", 1'b1, running);
      chk("gate", 1'b1, gate_enable);
   endtask
   task t_glitch;
      @(posedge clk);
      permit <= 1'b0;
      repeat (5) @(posedge clk);
      permit <= 1'b1;
      repeat (15) @(negedge clk);
      chk("glitch", 1'b1, gate_enable);
      pulse(1);
   endtask
   task t_single(input logic [1:0] k);
      @(posedge clk);
      solo <= k;
      permit <= 1'b0;
      repeat (45) @(negedge clk);
      chk("gate", 1'b0, gate_enable);
      chk("fault one", k == 2'h1, channel_one_loss_fault);
      chk("fault two", k == 2'h2, channel_two_loss_fault);
      pulse(0);
      chk("refused", 1'b1, start_refused_warning);
      @(posedge clk);
      permit <= 1'b1;
      repeat (15) @(negedge clk);
      pulse(0);
      chk("no restart", 1'b0, running);
      pulse(2);
      t_start();
   endtask
   task t_both(input logic [2:0] sel);
      @(posedge clk);
      {ind_sel, solo, lag} <= {sel, 2'h0, 8'h5};
      permit <= 1'b0;
      repeat (45) @(negedge clk);
      chk("gate", 1'b0, gate_enable);
      chk("no fault", 1'b0, channel_one_loss_fault);
      chk("indication", sel[1], torque_disable_fault);
      chk("warning", !sel[1], torque_disable_warning);
      @(posedge clk);
      permit <= 1'b1;
      repeat (30) @(negedge clk);
      chk("no auto start", 1'b0, running);
      pulse(0);
      chk("restart", !sel[2], running);
      if (sel[2]) begin
         pulse(2);
         t_start();
      end
      pulse(1);
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_start();
      t_glitch();
      t_start();
      t_single(2'h1);
      t_single(2'h2);
      t_both(3'h6);
      t_start();
      t_both(3'h0);
      test_done();
   end
endmodule
bind dctom_monitor dctom_monitor_props #(.FILT_CYC(FILT_CYC),
   .SKEW_LIM(SKEW_LIM)) dctom_monitor_props_inst (.clk(clk), .rst(rst),
   .disable_channel_one(disable_channel_one), .start_cmd(start_cmd),
   .fault_reset(fault_reset), .gate_enable(gate_enable),
   .running(running), .ch_one_ok(ch_one_ok), .ch_two_ok(ch_two_ok),
   .channel_one_loss_fault(channel_one_loss_fault),
   .channel_two_loss_fault(channel_two_loss_fault),
   .start_refused_warning(start_refused_warning));
